// *** logic/skb_pkg.sv ***
package skb_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PROG_CYCLE_US = 1000;
    localparam int PROG_CYCLE_CYC = (CLK_HZ / 1_000_000) * PROG_CYCLE_US;
    localparam int LONG_PRESS_S = 3;
    localparam int LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam int CFG_W = 5;
    localparam int STAT_W = 4;

    // Configuration word, bit 4 downward
    typedef struct packed {
        logic key_esc;
        logic key_ok;
        logic retentive;
        logic init_status;
        logic type_switch;
    } skb_cfg_s;

    localparam skb_cfg_s CFG_RESET = '{default: 1'b0};

    // Readback of live state, bit 3 downward
    typedef struct packed {
        logic edit_value;
        logic edit_mode;
        logic q;
        logic status;
    } skb_stat_s;

    // Front-panel keys
    typedef struct packed {
        logic ok;
        logic esc;
        logic up;
        logic down;
    } skb_keys_s;

endpackage

// *** logic/skb_cycle_strobe.sv ***
module skb_cycle_strobe #(
    parameter int DIV = 20000
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic strobe
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    if (DIV < 1) begin : g_bad_div
        $error("skb_cycle_strobe: DIV must be at least 1");
    end

    logic [CW-1:0] count;

    // ----------------------------------------
    // Divider for the program cycle
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
            strobe <= 1'b0;
        end else if (count == CW'(DIV - 1)) begin
            count <= '0;
            strobe <= 1'b1;
        end else begin
            count <= count + CW'(1);
            strobe <= 1'b0;
        end
    end

endmodule

// *** logic/skb_softkey.sv ***
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
module skb_softkey #(
    parameter int CYCLE_DIV = skb_pkg::PROG_CYCLE_CYC,
    parameter int LONG_PRESS = skb_pkg::LONG_PRESS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [skb_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Block signals
    input wire logic enable,
    input wire logic prog_start,
    input wire logic msg_shown,
    input wire skb_pkg::skb_keys_s keys,
    output logic q,
    output logic edit_mode
);
    import skb_pkg::*;

    localparam int LP_W = $clog2(LONG_PRESS + 1);

    if (LONG_PRESS < 2) begin : g_bad_long
        $error("skb_softkey: LONG_PRESS must be at least 2");
    end

    skb_cfg_s cfg;
    logic status;
    logic edit_value;
    logic strobe;
    logic en_prev;
    logic stat_prev;
    logic ok_prev;
    logic esc_prev;
    logic up_prev;
    logic down_prev;
    logic [LP_W-1:0] press_cnt;
    logic long_done;

    // ----------------------------------------
    // Program cycle strobe
    // ----------------------------------------
    skb_cycle_strobe #(
        .DIV(CYCLE_DIV)
    ) u_strobe (
        .sys_clk(sys_clk),
        .rst(rst),
        .strobe(strobe)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic bus_req;
    logic bus_wr;
    logic cfg_wr;
    logic status_wr;
    skb_stat_s stat_view;

    // Write takes effect at the edge where ack is high
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign cfg_wr = bus_wr && (wb_adr_i == REG_CFG);
    assign status_wr = bus_wr && (wb_adr_i == REG_STATUS);
    assign stat_view = '{edit_value: edit_value, edit_mode: edit_mode, q: q, status: status};

    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    // Read data, unmapped reads as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
                REG_CFG: wb_dat_o <= {{(32-CFG_W){1'b0}}, cfg};
                REG_STATUS: wb_dat_o <= {{(32-STAT_W){1'b0}}, stat_view};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // Configuration register, momentary type after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= skb_cfg_s'(wb_dat_i[CFG_W-1:0]);
        end
    end

    // ----------------------------------------
    // Front-panel keys
    // ----------------------------------------
    logic ok_fall;
    logic short_ok;
    logic ok_toggle;
    logic esc_toggle;
    logic edit_enter;
    logic edit_confirm;
    logic arrow_hit;
    logic long_hit;

    assign ok_fall = ok_prev && !keys.ok;
    assign short_ok = ok_fall && !long_done && msg_shown;
    assign ok_toggle = short_ok && !edit_mode && cfg.key_ok;
    assign esc_toggle = keys.esc && !esc_prev && msg_shown && !edit_mode && cfg.key_esc;
    assign long_hit = keys.ok && msg_shown && !long_done && (press_cnt == LP_W'(LONG_PRESS - 1));
    assign edit_enter = long_hit && !edit_mode;
    assign edit_confirm = short_ok && edit_mode;
    assign arrow_hit = (keys.up && !up_prev) || (keys.down && !down_prev);

    // Key history for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ok_prev <= 1'b0;
            esc_prev <= 1'b0;
            up_prev <= 1'b0;
            down_prev <= 1'b0;
        end else begin
            ok_prev <= keys.ok;
            esc_prev <= keys.esc;
            up_prev <= keys.up;
            down_prev <= keys.down;
        end
    end

    // Long-press timer, held while the message is hidden
    always_ff @(posedge sys_clk) begin
        if (rst || !keys.ok) begin
            press_cnt <= '0;
            long_done <= 1'b0;
        end else if (msg_shown && !long_done) begin
            press_cnt <= press_cnt + LP_W'(1);
            long_done <= long_hit;
        end
    end

    // Edit mode; arrows flip the pending value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            edit_mode <= 1'b0;
            edit_value <= 1'b0;
        end else if (edit_enter) begin
            edit_mode <= 1'b1;
            edit_value <= status;
        end else if (edit_mode) begin
            if (edit_confirm || !msg_shown) begin
                edit_mode <= 1'b0;
            end
            if (arrow_hit) begin
                edit_value <= !edit_value;
            end
        end
    end

    // ----------------------------------------
    // Status: bus, then restart, then keys
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status <= 1'b0;
        end else if (status_wr) begin
            status <= wb_dat_i[0];
        end else if (prog_start) begin
            if (!cfg.retentive) begin
                status <= cfg.init_status;
            end
        end else if (edit_confirm) begin
            status <= edit_value;
        end else if (ok_toggle || esc_toggle) begin
            status <= !status;
        end
    end

    // ----------------------------------------
    // Output, evaluated once per program cycle
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_prev <= 1'b0;
            stat_prev <= 1'b0;
        end else if (strobe) begin
            en_prev <= enable;
            stat_prev <= status;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (strobe) begin
            if (!enable) begin
                q <= 1'b0;
            end else if (!status) begin
                q <= 1'b0;
            end else if (cfg.type_switch) begin
                q <= 1'b1;
            end else begin
                q <= (!en_prev || !stat_prev);
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic key_act;
    assign key_act = edit_confirm || ok_toggle || esc_toggle;

    chk_fall_low: assert property (strobe && !enable |=> !q)
        else $error("output high after enable low");
    chk_switch_hold: assert property (
        strobe && enable && status && cfg.type_switch |=> q)
        else $error("switch output not held");
    chk_mom_single: assert property (strobe && q && !cfg.type_switch |=> !q)
        else $error("momentary pulse longer than one cycle");
    chk_off_low: assert property (strobe && !status |=> !q)
        else $error("output high with status off");
    chk_en_rise: assert property (
        strobe && enable && !en_prev && status |=> q)
        else $error("enable rise did not set output");
    chk_stat_rise: assert property (
        strobe && enable && en_prev && status && !stat_prev && !cfg.type_switch
        |=> q ##1 q [*1])
        else $error("status rise did not pulse");
    chk_q_strobe: assert property (!strobe |=> $stable(q))
        else $error("output moved between strobes");
    chk_init_load: assert property (
        prog_start && !cfg.retentive && !status_wr |=> status == $past(cfg.init_status))
        else $error("initial status not loaded");
    chk_retain_keep: assert property (
        prog_start && cfg.retentive && !status_wr |=> $stable(status))
        else $error("retentive status lost on restart");
    chk_ok_toggle: assert property (
        ok_toggle && !status_wr && !prog_start |=> status != $past(status))
        else $error("OK key did not toggle status");
    chk_esc_toggle: assert property (
        esc_toggle && !ok_toggle && !status_wr && !prog_start
        |=> status != $past(status))
        else $error("escape key did not toggle status");
    chk_long_edit: assert property (
        edit_enter |=> edit_mode && edit_value == $past(status))
        else $error("long OK press did not enter edit");
    chk_factory_type: assert property (
        @(posedge sys_clk) disable iff (1'b0) rst |=> !cfg.type_switch)
        else $error("type not momentary after reset");
    chk_mom_rise: assert property (
        strobe && enable && status && !cfg.type_switch && !en_prev
        |=> q)
        else $error("momentary set missed");

    cov_switch_on: cover property (strobe && enable && status && cfg.type_switch ##1 q);
    cov_mom_pulse: cover property (!q ##1 q && !cfg.type_switch);
    cov_edit_cfm: cover property (edit_mode ##1 edit_confirm);
    cov_key_tgl: cover property (key_act && !edit_confirm);

endmodule

// *** testbench/skb_panel_model.sv ***
// ----------------------------------------
// Front-panel key model
// ----------------------------------------
module skb_panel_model
    import skb_pkg::*;
(
    input wire logic sys_clk,
    output skb_pkg::skb_keys_s keys
);
    timeunit 1ns;
    timeprecision 1ns;

    // Released keys rest low
    initial keys = '0;

    // Hold one key for n clocks, then let it go
    // Returns only after the release edge, so the status it moves is settled
    task automatic press(input int which, input int n);
        @(posedge sys_clk);
        keys <= skb_keys_s'(4'h1 << which);
        repeat (n) @(posedge sys_clk);
        keys <= '0;
        @(posedge sys_clk);
    endtask
endmodule

// *** testbench/skb_softkey_bench.sv ***
// ----------------------------------------
// Softkey block bench
// ----------------------------------------
module skb_softkey_bench;
    import skb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CDIV = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic [31:0] rd;
    logic [31:0] qc;
    logic ack;
    logic enable = 1'b0;
    logic prog_start = 1'b0;
    logic msg_shown = 1'b0;
    logic q;
    logic edit_mode;
    skb_keys_s keys;
    int num_errors = 0;
    int checks = 0;

    // Clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    skb_panel_model panel (.sys_clk(sys_clk), .keys(keys));

    skb_softkey #(.CYCLE_DIV(CDIV), .LONG_PRESS(10)) dut (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .enable(enable), .prog_start(prog_start),
        .msg_shown(msg_shown), .keys(keys), .q(q), .edit_mode(edit_mode)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // One classic Wishbone cycle, read data kept in rd
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic count_q(input int n);
        qc = 0;
        repeat (n) begin
            @(posedge sys_clk);
            qc += {31'h0, q === 1'b1};
        end
    endtask

    task automatic restart;
        prog_start <= 1'b1;
        @(posedge sys_clk);
        prog_start <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        wb(1'b0, REG_CFG, 32'h0);
        check("cfg after reset", rd, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        check("unmapped read", rd, 32'h0);
    endtask

    task automatic t_momentary;
        wb(1'b1, REG_CFG, 32'h0);
        wb(1'b1, REG_STATUS, 32'h1);
        enable <= 1'b1;
        count_q(6 * CDIV);
        check("pulse on enable", qc, CDIV);
        wb(1'b1, REG_STATUS, 32'h0);
        repeat (2 * CDIV) @(posedge sys_clk);
        wb(1'b1, REG_STATUS, 32'h1);
        count_q(6 * CDIV);
        check("pulse on status on", qc, CDIV);
    endtask

    task automatic t_switch;
        wb(1'b1, REG_CFG, 32'h1);
        repeat (2 * CDIV) @(posedge sys_clk);
        count_q(4 * CDIV);
        check("switch level", qc, 4 * CDIV);
        wb(1'b1, REG_STATUS, 32'h0);
        repeat (2 * CDIV) @(posedge sys_clk);
        check("q after off", q, 32'h0);
        wb(1'b1, REG_STATUS, 32'h1);
        repeat (2 * CDIV) @(posedge sys_clk);
        enable <= 1'b0;
        repeat (2 * CDIV) @(posedge sys_clk);
        check("q after enable fall", q, 32'h0);
    endtask

    task automatic t_start;
        wb(1'b1, REG_CFG, 32'h2);
        wb(1'b1, REG_STATUS, 32'h0);
        restart();
        wb(1'b0, REG_STATUS, 32'h0);
        check("initial status", rd[0], 32'h1);
        wb(1'b1, REG_CFG, 32'h4);
        restart();
        wb(1'b0, REG_STATUS, 32'h0);
        check("kept status", rd[0], 32'h1);
    endtask

    task automatic t_keys;
        wb(1'b1, REG_CFG, 32'h18);
        wb(1'b1, REG_STATUS, 32'h0);
        msg_shown <= 1'b1;
        panel.press(3, 2);
        wb(1'b0, REG_STATUS, 32'h0);
        check("ok toggle", rd[0], 32'h1);
        panel.press(2, 2);
        wb(1'b0, REG_STATUS, 32'h0);
        check("esc toggle", rd[0], 32'h0);
        panel.press(3, 12);
        check("edit entry", edit_mode, 32'h1);
        panel.press(1, 2);
        panel.press(3, 2);
        wb(1'b0, REG_STATUS, 32'h0);
        check("edit confirm", rd[2:0], 32'h1);
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_momentary();
        t_switch();
        t_start();
        t_keys();
        close_out();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end
endmodule
